// >>> rtl/ctc_defines.svh
// constants of the cartridge transfer controller: offsets, fields, resets, times
// assumes: included by bare name from the top module and the testbench
`ifndef CTC_DEFINES_SVH
`define CTC_DEFINES_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CTC_ADR_LANG   8'h00
`define CTC_ADR_SETUP  8'h04
`define CTC_ADR_STATUS 8'h08
`define CTC_ADR_BYTES  8'h0C
`define CTC_ADR_BLOCKS 8'h10
`define CTC_ADR_SWITCH 8'h14
// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define CTC_SU_TOCART 0
`define CTC_SU_BANK   1
`define CTC_SU_SYS    2
`define CTC_SU_COMB   3
`define CTC_SU_GO     4
`define CTC_SU_ACK    5
// ----------------------------------------------------------------
// switch positions in the sampled switch word
// ----------------------------------------------------------------
`define CTC_SW_LOAD 0
`define CTC_SW_SAVE 1
`define CTC_SW_MAN  2
`define CTC_SW_TYPE 3
`define CTC_SW_TWE  4
`define CTC_SW_CWE  5
`define CTC_SW_BANK 6
`define CTC_SW_COMB 7
// ----------------------------------------------------------------
// reset values and error codes
// ----------------------------------------------------------------
`define CTC_SETUP_RST 4'h0
`define CTC_LANG_RST  2'h0
`define CTC_SW_RST    8'h00
`define CTC_ERR_NONE  3'h0
`define CTC_ERR_MODE  3'h1
`define CTC_ERR_PROT  3'h2
`define CTC_ERR_DATA  3'h3
`define CTC_ERR_FLASH 3'h4
// ----------------------------------------------------------------
// sizes and times
// ----------------------------------------------------------------
`define CTC_CLK_KHZ     40000
`define CTC_SLOW_MS     1000
`define CTC_FAST_MS     500
`define CTC_BANK_BLOCKS 16
`define CTC_BANK_KB     1024
`define CTC_PREP_CYC    16
`define CTC_SYNC_CYC    3
`endif

// >>> rtl/ctc_pkg.sv
// types of the cartridge transfer controller
// assumes: ctc_defines.svh on the include path
package ctc_pkg;
    typedef enum logic [8:0] {
        S_INIT   = 9'h001,
        S_LANG   = 9'h002,
        S_SETUP  = 9'h004,
        S_CHECK  = 9'h008,
        S_PREP   = 9'h010,
        S_XFER   = 9'h020,
        S_VERIFY = 9'h040,
        S_DONE   = 9'h080,
        S_ERR    = 9'h100
    } ctc_state_e;
    typedef enum logic [3:0] {
        LMP_OFF  = 4'h1,
        LMP_ON   = 4'h2,
        LMP_SLOW = 4'h4,
        LMP_FAST = 4'h8
    } ctc_lamp_e;
endpackage

// >>> rtl/ctc_blink.sv
// activity lamp driver: off, steady, slow or fast blink
// assumes: mode comes from logic on the same clock
`timescale 1ns/1ps
module ctc_blink import ctc_pkg::*; #(
    parameter int unsigned SLOW_CYC = 40000000,
    parameter int unsigned FAST_CYC = 20000000
) (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire ctc_lamp_e mode_i,
    output logic           lamp_o
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    ctc_lamp_e   mode_r;
    logic        lamp_r;
    logic        lamp_nxt;
    logic [31:0] lim;

    // ----------------------------------------------------------------
    // blink timer, restarted on every mode change
    // ----------------------------------------------------------------
    always_comb begin
        lim      = (mode_i == LMP_SLOW) ? SLOW_CYC : FAST_CYC;
        cnt_nxt  = cnt_r + 32'h1;
        lamp_nxt = lamp_r;
        if (mode_i != mode_r) begin
            cnt_nxt  = 32'h0;
            lamp_nxt = (mode_i != LMP_OFF);
        end else begin
            case (mode_i)
                LMP_OFF: begin
                    lamp_nxt = 1'b0;
                    cnt_nxt  = 32'h0;
                end
                LMP_ON: begin
                    lamp_nxt = 1'b1;
                    cnt_nxt  = 32'h0;
                end
                default: begin
                    // lamp changes every interval
                    if (cnt_r >= lim - 32'h1) begin
                        cnt_nxt  = 32'h0;
                        lamp_nxt = ~lamp_r;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 32'h0;
            mode_r <= LMP_OFF;
            lamp_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            mode_r <= mode_i;
            lamp_r <= lamp_nxt;
        end
    end

    assign lamp_o = lamp_r;
endmodule

// >>> rtl/ctc_top.sv
// cartridge transfer controller: switch decode, checks and transfer sequencing
// assumes: classic Wishbone master, byte mover answering xfer_req_o on this clock
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ctc_defines.svh"
module ctc_top import ctc_pkg::*; #(
    parameter int unsigned BANK_BYTES = `CTC_BANK_KB * 1024,
    parameter int unsigned SLOW_CYC   = `CTC_SLOW_MS * `CTC_CLK_KHZ,
    parameter int unsigned FAST_CYC   = `CTC_FAST_MS * `CTC_CLK_KHZ,
    parameter int unsigned PREP_CYC   = `CTC_PREP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [7:0]  sw_i,
    input  wire logic [1:0]  bank_sys_i,
    input  wire logic        xfer_ack_i,
    input  wire logic        xfer_err_i,
    output logic             xfer_req_o,
    output logic             xfer_verify_o,
    output logic             xfer_to_cart_o,
    output logic             xfer_bank_o,
    output logic             xfer_sys_o,
    output logic             lamp_o,
    output logic             buzzer_o
);
    localparam int unsigned BLK_SH = $clog2(BANK_BYTES / `CTC_BANK_BLOCKS);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic ctc_onehot3(input logic [2:0] v);
        return (v == 3'b001) || (v == 3'b010) || (v == 3'b100);
    endfunction

    // returns {bank, system} for one pass
    function automatic logic [1:0] ctc_plan(input logic p, input logic comb,
                                            input logic tocart, input logic bnk,
                                            input logic typ, input logic sysbank);
        if (!comb)
            return {bnk, typ};
        else if (tocart)
            return {p, ~p};
        else
            return {p ^ sysbank, ~p};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [9:0] sy1_r;
    logic [9:0] sy2_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1_r <= 10'h000;
            sy2_r <= 10'h000;
        end else begin
            sy1_r <= {bank_sys_i, sw_i};
            sy2_r <= sy1_r;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ctc_state_e  st_r, st_nxt;
    logic [7:0]  sw_r, sw_nxt;
    logic [1:0]  bsys_r, bsys_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] bytes_r, bytes_nxt;
    logic        pass_r, pass_nxt;
    logic [2:0]  err_r, err_nxt;
    logic [1:0]  lang_r, lang_nxt;
    logic [3:0]  su_r, su_nxt;
    logic        req_r, req_nxt;
    logic        ver_r, ver_nxt;
    logic        tocart_r, tocart_nxt;
    logic        bank_r, bank_nxt;
    logic        sys_r, sys_nxt;
    logic        buz_r, buz_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        man, tocart, comb, typ, bnk, mode_ok, wr;
    logic [2:0]  chk_err;
    logic [1:0]  plan;
    ctc_lamp_e   lmode;

    // ----------------------------------------------------------------
    // decode of the held switches and panel setup
    // ----------------------------------------------------------------
    always_comb begin
        man     = sw_r[`CTC_SW_MAN];
        mode_ok = ctc_onehot3(sw_r[2:0]);
        tocart  = man ? su_r[`CTC_SU_TOCART] : sw_r[`CTC_SW_SAVE];
        comb    = man ? su_r[`CTC_SU_COMB] : sw_r[`CTC_SW_COMB];
        typ     = man ? su_r[`CTC_SU_SYS] : sw_r[`CTC_SW_TYPE];
        bnk     = man ? su_r[`CTC_SU_BANK] : sw_r[`CTC_SW_BANK];
        if (!mode_ok)
            chk_err = `CTC_ERR_MODE;
        else if (tocart ? !sw_r[`CTC_SW_CWE] : !sw_r[`CTC_SW_TWE])
            chk_err = `CTC_ERR_PROT;
        else if (!tocart && comb && (bsys_r[0] == bsys_r[1]))
            chk_err = `CTC_ERR_DATA;
        else if (!tocart && !comb && (bsys_r[bnk] != typ))
            chk_err = `CTC_ERR_DATA;
        else
            chk_err = `CTC_ERR_NONE;
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    always_comb begin
        ack_nxt = cyc_i && stb_i && !ack_r;
        wr      = cyc_i && stb_i && we_i && ack_r && sel_i[0];
        dat_nxt = 32'h0;
        case (adr_i)
            `CTC_ADR_LANG:   dat_nxt = {30'h0, lang_r};
            `CTC_ADR_SETUP:  dat_nxt = {28'h0, su_r};
            `CTC_ADR_STATUS: dat_nxt = {20'h0, err_r, st_r};
            `CTC_ADR_BYTES:  dat_nxt = bytes_r;
            `CTC_ADR_BLOCKS: dat_nxt = bytes_r >> BLK_SH;
            `CTC_ADR_SWITCH: dat_nxt = {22'h0, bsys_r, sw_r};
            default:         dat_nxt = 32'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        sw_nxt    = sw_r;
        bsys_nxt  = bsys_r;
        cnt_nxt   = cnt_r;
        bytes_nxt = bytes_r;
        pass_nxt  = pass_r;
        err_nxt   = err_r;
        lang_nxt  = lang_r;
        su_nxt    = su_r;
        case (st_r)
            S_INIT: begin
                cnt_nxt = cnt_r + 32'h1;
                if (cnt_r == `CTC_SYNC_CYC) begin
                    sw_nxt   = sy2_r[7:0];
                    bsys_nxt = sy2_r[9:8];
                end else if (cnt_r > `CTC_SYNC_CYC) begin
                    cnt_nxt = 32'h0;
                    if (!mode_ok) begin
                        st_nxt  = S_ERR;
                        err_nxt = `CTC_ERR_MODE;
                    end else if (man)
                        st_nxt = S_LANG;
                    else
                        st_nxt = S_CHECK;
                end
            end
            S_LANG: begin
                if (wr && adr_i == `CTC_ADR_LANG) begin
                    lang_nxt = {1'b1, dat_i[0]};
                    st_nxt   = S_SETUP;
                end
            end
            S_SETUP: begin
                if (wr && adr_i == `CTC_ADR_SETUP) begin
                    su_nxt = dat_i[3:0];
                    if (dat_i[`CTC_SU_GO])
                        st_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                cnt_nxt   = 32'h0;
                bytes_nxt = 32'h0;
                pass_nxt  = 1'b0;
                if (chk_err != `CTC_ERR_NONE) begin
                    st_nxt  = S_ERR;
                    err_nxt = chk_err;
                end else
                    st_nxt = S_PREP;
            end
            S_PREP: begin
                cnt_nxt = cnt_r + 32'h1;
                if (cnt_r >= PREP_CYC - 1) begin
                    cnt_nxt = 32'h0;
                    st_nxt  = S_XFER;
                end
            end
            S_XFER, S_VERIFY: begin
                if (xfer_err_i) begin
                    st_nxt  = S_ERR;
                    err_nxt = `CTC_ERR_FLASH;
                end else if (xfer_ack_i) begin
                    cnt_nxt   = cnt_r + 32'h1;
                    bytes_nxt = bytes_r + 32'h1;
                    if (cnt_r == BANK_BYTES - 1) begin
                        cnt_nxt = 32'h0;
                        if (comb && !pass_r)
                            pass_nxt = 1'b1;
                        else begin
                            pass_nxt  = 1'b0;
                            bytes_nxt = 32'h0;
                            st_nxt    = (st_r == S_XFER) ? S_VERIFY : S_DONE;
                        end
                    end
                end
            end
            S_DONE: st_nxt = S_DONE;
            S_ERR: begin
                // only a manual protect error can be acknowledged
                if (man && err_r == `CTC_ERR_PROT && wr && adr_i == `CTC_ADR_SETUP
                    && dat_i[`CTC_SU_ACK]) begin
                    err_nxt = `CTC_ERR_NONE;
                    st_nxt  = S_SETUP;
                end
            end
            default: st_nxt = S_INIT;
        endcase
        plan       = ctc_plan(pass_nxt, comb, tocart, bnk, typ, bsys_r[1]);
        req_nxt    = (st_nxt == S_XFER) || (st_nxt == S_VERIFY);
        ver_nxt    = (st_nxt == S_VERIFY);
        tocart_nxt = tocart;
        bank_nxt   = plan[1];
        sys_nxt    = plan[0];
        buz_nxt    = (st_nxt == S_ERR);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= S_INIT;
            sw_r     <= `CTC_SW_RST;
            bsys_r   <= 2'h0;
            cnt_r    <= 32'h0;
            bytes_r  <= 32'h0;
            pass_r   <= 1'b0;
            err_r    <= `CTC_ERR_NONE;
            lang_r   <= `CTC_LANG_RST;
            su_r     <= `CTC_SETUP_RST;
            req_r    <= 1'b0;
            ver_r    <= 1'b0;
            tocart_r <= 1'b0;
            bank_r   <= 1'b0;
            sys_r    <= 1'b0;
            buz_r    <= 1'b0;
            ack_r    <= 1'b0;
            dat_r    <= 32'h0;
        end else begin
            st_r     <= st_nxt;
            sw_r     <= sw_nxt;
            bsys_r   <= bsys_nxt;
            cnt_r    <= cnt_nxt;
            bytes_r  <= bytes_nxt;
            pass_r   <= pass_nxt;
            err_r    <= err_nxt;
            lang_r   <= lang_nxt;
            su_r     <= su_nxt;
            req_r    <= req_nxt;
            ver_r    <= ver_nxt;
            tocart_r <= tocart_nxt;
            bank_r   <= bank_nxt;
            sys_r    <= sys_nxt;
            buz_r    <= buz_nxt;
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
        end
    end

    // ----------------------------------------------------------------
    // activity lamp
    // ----------------------------------------------------------------
    always_comb begin
        case (st_r)
            S_ERR:            lmode = LMP_FAST;
            S_PREP:           lmode = man ? LMP_OFF : LMP_SLOW;
            S_XFER, S_VERIFY: lmode = man ? LMP_OFF : LMP_FAST;
            S_DONE:           lmode = man ? LMP_OFF : LMP_ON;
            default:          lmode = LMP_OFF;
        endcase
    end

    ctc_blink #(
        .SLOW_CYC (SLOW_CYC),
        .FAST_CYC (FAST_CYC)
    ) u_blink (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .mode_i (lmode),
        .lamp_o (lamp_o)
    );

    assign dat_o          = dat_r;
    assign ack_o          = ack_r;
    assign xfer_req_o     = req_r;
    assign xfer_verify_o  = ver_r;
    assign xfer_to_cart_o = tocart_r;
    assign xfer_bank_o    = bank_r;
    assign xfer_sys_o     = sys_r;
    assign buzzer_o       = buz_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_prep_end;
        st_r == S_PREP && cnt_r >= PREP_CYC - 1;
    endsequence
    sequence s_moving;
        st_r == S_XFER && xfer_req_o;
    endsequence

    property p_mode_err;
        st_r == S_INIT && cnt_r > `CTC_SYNC_CYC && !mode_ok
            |=> st_r == S_ERR && err_r == `CTC_ERR_MODE ##1 buzzer_o;
    endproperty
    a_mode_err: assert property (p_mode_err) else $error("mode error missed");

    property p_prot;
        st_r == S_CHECK && chk_err == `CTC_ERR_PROT |=> err_r == `CTC_ERR_PROT;
    endproperty
    a_prot: assert property (p_prot) else $error("protect error missed");

    property p_term_we;
        xfer_req_o && !xfer_to_cart_o |-> sw_r[`CTC_SW_TWE];
    endproperty
    a_term_we: assert property (p_term_we) else $error("terminal write not enabled");

    property p_cart_we;
        xfer_req_o && xfer_to_cart_o |-> sw_r[`CTC_SW_CWE];
    endproperty
    a_cart_we: assert property (p_cart_we) else $error("cartridge write not enabled");

    property p_comb_save;
        xfer_req_o && xfer_to_cart_o && comb |-> xfer_bank_o == !xfer_sys_o;
    endproperty
    a_comb_save: assert property (p_comb_save) else $error("combined save bank wrong");

    property p_comb_load;
        xfer_req_o && !xfer_to_cart_o && comb |-> bsys_r[0] != bsys_r[1];
    endproperty
    a_comb_load: assert property (p_comb_load) else $error("combined load banks bad");

    property p_phase;
        s_prep_end |=> s_moving;
    endproperty
    a_phase: assert property (p_phase) else $error("preparing not followed by move");

    property p_done_lamp;
        st_r == S_DONE && !man |=> lamp_o;
    endproperty
    a_done_lamp: assert property (p_done_lamp) else $error("lamp not lit when done");

    property p_man_lamp;
        man && st_r != S_ERR |=> !lamp_o;
    endproperty
    a_man_lamp: assert property (p_man_lamp) else $error("lamp lit in manual");

    property p_err_hold;
        st_r == S_ERR && err_r != `CTC_ERR_PROT |=> st_r == S_ERR && buzzer_o;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error state left");

    property p_sw_hold;
        st_r != S_INIT |=> $stable(sw_r) && $stable(bsys_r);
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("switches changed");

    property p_lang_first;
        st_r == S_SETUP |-> lang_r[1] && man;
    endproperty
    a_lang_first: assert property (p_lang_first) else $error("setup before language");
endmodule

// >>> verification/ctc_mover_model.sv
// byte mover model on the cartridge flash side of the transfer controller
// assumes: same clock as the controller; answers only while it is requested
`timescale 1ns/1ps
module ctc_mover_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic req_i,
    input  wire logic slow_i,
    input  wire logic inj_i,
    output logic      ack_o,
    output logic      err_o
);
    logic [1:0] ph_r;
    // --------------------------------------------------------------
    // one byte per cycle, or every other cycle when slow
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i) begin
            ph_r  <= 2'h0;
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ph_r  <= ph_r + 2'h1;
            ack_o <= slow_i ? ph_r[0] : 1'b1;
            err_o <= inj_i && (ph_r == 2'h3);
        end
    end
endmodule

// >>> verification/testbench.sv
// self-checking bench of the cartridge transfer controller
// assumes: ctc_defines.svh on the include path; mover model beside it
`timescale 1ns/1ps
`include "ctc_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
    typedef struct packed {
        logic [7:0] sw;
        logic [1:0] bs;
        logic       sl;
        logic       inj;
        logic [2:0] err;
        logic [8:0] acks;
        logic [2:0] ps;
    } ctc_row_s;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic        slow = 1'b0, inj = 1'b0, req_d = 1'b0, lamp_seen = 1'b0;
    logic [7:0]  adr_i = 8'h00, sw_i = 8'h00;
    logic [31:0] dat_i = 32'h0, q, dat_o;
    logic [1:0]  bank_sys_i = 2'h0;
    logic [2:0]  pass = 3'h0;
    logic        ack_o, xfer_ack_i, xfer_err_i, xfer_req_o, xfer_verify_o;
    logic        xfer_to_cart_o, xfer_bank_o, xfer_sys_o, lamp_o, buzzer_o;
    int          n_mismatch = 0, n_checks = 0, n_acks = 0, n_vacks = 0, i;
    // every automatic row keeps the transfer source write-protected
    ctc_row_s    rows [13] = '{
        '{8'h00, 2'h0, 1'b0, 1'b0, 3'h1, 9'h000, 3'h0},
        '{8'h03, 2'h0, 1'b0, 1'b0, 3'h1, 9'h000, 3'h0},
        '{8'h07, 2'h0, 1'b0, 1'b0, 3'h1, 9'h000, 3'h0},
        '{8'h02, 2'h0, 1'b0, 1'b0, 3'h2, 9'h000, 3'h0},
        '{8'h01, 2'h0, 1'b0, 1'b0, 3'h2, 9'h000, 3'h0},
        '{8'h62, 2'h0, 1'b0, 1'b0, 3'h0, 9'h080, 3'h6},
        '{8'hEA, 2'h0, 1'b1, 1'b0, 3'h0, 9'h100, 3'h5},
        '{8'h19, 2'h1, 1'b0, 1'b0, 3'h0, 9'h080, 3'h1},
        '{8'h19, 2'h2, 1'b0, 1'b0, 3'h3, 9'h000, 3'h0},
        '{8'h51, 2'h2, 1'b0, 1'b0, 3'h3, 9'h000, 3'h0},
        '{8'h91, 2'h2, 1'b0, 1'b0, 3'h0, 9'h100, 3'h3},
        '{8'h91, 2'h3, 1'b0, 1'b0, 3'h3, 9'h000, 3'h0},
        '{8'h62, 2'h0, 1'b0, 1'b1, 3'h4, 9'h000, 3'h0}};

    always #12.5 clk_i = ~clk_i;

    ctc_top #(.BANK_BYTES(64), .SLOW_CYC(8), .FAST_CYC(4), .PREP_CYC(4)) i_ctc_top (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hF),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .sw_i(sw_i), .bank_sys_i(bank_sys_i), .xfer_ack_i(xfer_ack_i),
        .xfer_err_i(xfer_err_i), .xfer_req_o(xfer_req_o), .xfer_verify_o(xfer_verify_o),
        .xfer_to_cart_o(xfer_to_cart_o), .xfer_bank_o(xfer_bank_o),
        .xfer_sys_o(xfer_sys_o), .lamp_o(lamp_o), .buzzer_o(buzzer_o));
    ctc_mover_model i_ctc_mover_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(xfer_req_o),
        .slow_i(slow), .inj_i(inj), .ack_o(xfer_ack_i), .err_o(xfer_err_i));

    // --------------------------------------------------------------
    // transfer monitor: byte count, first pass setup, lamp activity
    // --------------------------------------------------------------
    always @(posedge clk_i) begin
        req_d <= xfer_req_o;
        if (rst_i) begin
            n_acks    = 0;
            n_vacks   = 0;
            lamp_seen <= 1'b0;
        end
        if (xfer_req_o && xfer_ack_i) n_acks++;
        if (xfer_req_o && xfer_ack_i && xfer_verify_o) n_vacks++;
        if (xfer_req_o && !req_d) pass <= {xfer_to_cart_o, xfer_bank_o, xfer_sys_o};
        if (xfer_req_o && lamp_o) lamp_seen <= 1'b1;
    end

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic start(input logic [7:0] s, input logic [1:0] b);
        sw_i       <= s;
        bank_sys_i <= b;
        rst_i      <= 1'b1;
        repeat (5) @(posedge clk_i);
        `CHK({ack_o, xfer_req_o, xfer_verify_o, lamp_o, buzzer_o, dat_o}, 37'h0)
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask

    task automatic finish_run();
        do begin
            wb(1'b0, `CTC_ADR_STATUS, 32'h0);
        end while (q[8:0] !== 9'h080 && q[8:0] !== 9'h100);
    endtask

    task wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        for (i = 0; i < 13; i++) begin
            slow <= rows[i].sl;
            inj  <= rows[i].inj;
            start(rows[i].sw, rows[i].bs);
            finish_run();
            `CHK(q[11:9], rows[i].err)
            if (rows[i].err == 3'h0) begin
                `CHK(n_acks, rows[i].acks)
                `CHK(2 * n_vacks, rows[i].acks)
                `CHK(pass, rows[i].ps)
                `CHK(lamp_seen, 1'b1)
                repeat (3) @(posedge clk_i);
                `CHK({lamp_o, buzzer_o}, 2'b10)
                repeat (5) @(posedge clk_i);
                `CHK(lamp_o, 1'b1)
            end else `CHK(buzzer_o, 1'b1)
            sw_i <= ~rows[i].sw;
            repeat (2) @(posedge clk_i);
            wb(1'b0, `CTC_ADR_SWITCH, 32'h0);
            `CHK(q[9:0], {rows[i].bs, rows[i].sw})
        end
        // manual mode: language, refused save, acknowledge, then load
        inj <= 1'b0;
        start(8'h14, 2'h1);
        wb(1'b0, `CTC_ADR_STATUS, 32'h0);
        `CHK(q[8:0], 9'h002)
        wb(1'b1, `CTC_ADR_LANG, 32'h1);
        wb(1'b0, `CTC_ADR_STATUS, 32'h0);
        `CHK(q[8:0], 9'h004)
        wb(1'b1, `CTC_ADR_SETUP, 32'h11);
        repeat (3) @(posedge clk_i);
        wb(1'b0, `CTC_ADR_STATUS, 32'h0);
        `CHK({q[11:0], buzzer_o}, {12'h500, 1'b1})
        wb(1'b1, `CTC_ADR_SETUP, 32'h20);
        wb(1'b0, `CTC_ADR_STATUS, 32'h0);
        `CHK(q[8:0], 9'h004)
        wb(1'b1, `CTC_ADR_SETUP, 32'h14);
        // progress registers read mid-transmit, one byte moved per cycle
        wait (n_acks == 40);
        wb(1'b0, `CTC_ADR_BYTES, 32'h0);
        `CHK(q, 32'h28)
        wb(1'b0, `CTC_ADR_BLOCKS, 32'h0);
        `CHK(q, 32'h0A)
        finish_run();
        `CHK({q[11:0], pass, lamp_seen}, {12'h080, 3'b001, 1'b0})
        `CHK(n_acks, 128)
        `CHK(n_vacks, 64)
        wrap_up();
    end
endmodule
